// file: io_selector_pkg.sv
// shared constants and carrier types for the coded channel selector
package io_selector_pkg;
  localparam int NCHAN = 8;
  localparam int CHAN_W = 3;
  localparam int UNIT_W = 5;
  localparam int CNT_W = 21;
  localparam int CLK_HZ = 125_000_000;
  localparam int TERMS = 3;
  localparam int NRATES = 7;
  localparam int RATE_BPS [NRATES] = '{110, 300, 1200, 1800, 2400, 4800,
                                       9600};
  localparam logic [2:0] RATE_RESET = 3'h6;
  localparam logic [CHAN_W:0] MEM_TX_BASE = 4'h0;
  localparam logic [CHAN_W:0] MEM_RX_BASE = 4'h8;
  localparam int MEM_DEPTH = 16;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_POLL = 2'h2;
  localparam logic [1:0] OP_CONFIG = 2'h3;
  localparam int CFG_BACKUP_BIT = 3;
  localparam int MP_W = 3;
  localparam int MP_CLEAR = 0;
  localparam int MP_LOOP = 1;
  localparam int MP_MUTE = 2;
  localparam int TX_LAST_BIT = 9;
  localparam int RX_STOP_BIT = 9;
  localparam logic [9:0] TX_IDLE = 10'h3FF;

  typedef struct packed {
    logic valid;
    logic [UNIT_W-1:0] unit;
    logic [CHAN_W-1:0] chan;
    logic [1:0] op;
    logic [1:0] replySel;
    logic [7:0] data;
  } order_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } reply_t;
endpackage

// file: coded_io_channel_selector.sv
// coded channel selector with its line units
`timescale 1ns/1ns

module io_line_unit (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [io_selector_pkg::CNT_W-1:0] bitCycles,
  input wire logic txGo,
  input wire logic [7:0] txByte,
  input wire logic rxd,
  output logic txBusy,
  output logic txd,
  output logic rxStb,
  output logic [7:0] rxByte
);
  logic [io_selector_pkg::CNT_W-1:0] txCnt_r, txCnt_nxt, rxCnt_r, rxCnt_nxt;
  logic [3:0] txBit_r, txBit_nxt, rxBit_r, rxBit_nxt;
  logic [9:0] txSh_r, txSh_nxt;
  logic [7:0] rxSh_r, rxSh_nxt, rxByte_r, rxByte_nxt;
  logic txBusy_r, txBusy_nxt, rxBusy_r, rxBusy_nxt, rxStb_r, rxStb_nxt;
  logic [io_selector_pkg::CNT_W-1:0] rxTarget;

  always_comb begin
    txCnt_nxt = txCnt_r;
    txBit_nxt = txBit_r;
    txSh_nxt = txSh_r;
    txBusy_nxt = txBusy_r;
    if (!txBusy_r) begin
      if (txGo) begin
        txSh_nxt = {1'b1, txByte, 1'b0};
        txBusy_nxt = 1'b1;
        txCnt_nxt = '0;
        txBit_nxt = '0;
      end
    end else if (txCnt_r == bitCycles - 1'b1) begin
      txCnt_nxt = '0;
      txSh_nxt = {1'b1, txSh_r[9:1]};
      txBit_nxt = txBit_r + 1'b1;
      if (txBit_r == 4'(io_selector_pkg::TX_LAST_BIT)) begin
        txBusy_nxt = 1'b0;
      end
    end else begin
      txCnt_nxt = txCnt_r + 1'b1;
    end
  end

  // start bit sampled at half a bit, the rest at whole bits
  always_comb begin
    rxCnt_nxt = rxCnt_r;
    rxBit_nxt = rxBit_r;
    rxSh_nxt = rxSh_r;
    rxBusy_nxt = rxBusy_r;
    rxByte_nxt = rxByte_r;
    rxStb_nxt = 1'b0;
    rxTarget = (rxBit_r == 4'h0) ? (bitCycles >> 1) : bitCycles - 1'b1;
    if (!rxBusy_r) begin
      if (!rxd) begin
        rxBusy_nxt = 1'b1;
        rxCnt_nxt = '0;
        rxBit_nxt = '0;
      end
    end else if (rxCnt_r >= rxTarget) begin
      rxCnt_nxt = '0;
      rxBit_nxt = rxBit_r + 1'b1;
      if (rxBit_r == 4'h0) begin
        if (rxd) begin
          rxBusy_nxt = 1'b0;
        end
      end else if (rxBit_r == 4'(io_selector_pkg::RX_STOP_BIT)) begin
        rxBusy_nxt = 1'b0;
        if (rxd) begin
          rxStb_nxt = 1'b1;
          rxByte_nxt = rxSh_r;
        end
      end else begin
        rxSh_nxt = {rxd, rxSh_r[7:1]};
      end
    end else begin
      rxCnt_nxt = rxCnt_r + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      txCnt_r <= '0;
      txBit_r <= '0;
      txSh_r <= io_selector_pkg::TX_IDLE;
      txBusy_r <= 1'b0;
      rxCnt_r <= '0;
      rxBit_r <= '0;
      rxSh_r <= '0;
      rxBusy_r <= 1'b0;
      rxByte_r <= '0;
      rxStb_r <= 1'b0;
    end else begin
      txCnt_r <= txCnt_nxt;
      txBit_r <= txBit_nxt;
      txSh_r <= txSh_nxt;
      txBusy_r <= txBusy_nxt;
      rxCnt_r <= rxCnt_nxt;
      rxBit_r <= rxBit_nxt;
      rxSh_r <= rxSh_nxt;
      rxBusy_r <= rxBusy_nxt;
      rxByte_r <= rxByte_nxt;
      rxStb_r <= rxStb_nxt;
    end
  end

  assign txBusy = txBusy_r;
  assign txd = txSh_r[0];
  assign rxStb = rxStb_r;
  assign rxByte = rxByte_r;
endmodule

// Operation
// - The selector keeps its own code and ignores orders with any other, save the partner code for backed-up channels while partnerFail is set.
// - The channel field picks the line unit; the order is decoded, applied.
// - One selector serves up to eight line units, one channel each.
// - Each line unit sends RS232C serial data to three identical terminals.
// - Reply data goes out on reply bus 0, reply bus 1, or both.
// - Maintenance pulse points from central control steer maintenance.
// - Software sets each channel's line rate to one of seven, full duplex.
// - Channel data moves only through fixed slots of the data memory.
// - A processor unit holds up to sixteen channels in one or two groups.
// - The partner unit may back up channels so traffic survives a failure.
module coded_io_channel_selector #(
  parameter logic [io_selector_pkg::UNIT_W-1:0] UNIT_CODE = 5'h01,
  parameter logic [io_selector_pkg::UNIT_W-1:0] PARTNER_CODE = 5'h02,
  parameter int CLK_HZ = io_selector_pkg::CLK_HZ
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire io_selector_pkg::order_t wrBus0,
  input wire io_selector_pkg::order_t wrBus1,
  input wire logic [io_selector_pkg::MP_W-1:0] maintPulse,
  input wire logic partnerFail,
  input wire logic [io_selector_pkg::NCHAN-1:0] rxd,
  output logic [io_selector_pkg::NCHAN-1:0][io_selector_pkg::TERMS-1:0]
    termTxd,
  output io_selector_pkg::reply_t replyBus0,
  output io_selector_pkg::reply_t replyBus1
);
  localparam int N = io_selector_pkg::NCHAN;

  logic [7:0] mem_r [io_selector_pkg::MEM_DEPTH];
  logic [7:0] mem_nxt [io_selector_pkg::MEM_DEPTH];
  logic [N-1:0] txPend_r, txPend_nxt, srq_r, srq_nxt, backup_r, backup_nxt;
  logic [N-1:0][2:0] rate_r, rate_nxt;
  io_selector_pkg::reply_t reply0_r, reply0_nxt, reply1_r, reply1_nxt;
  logic [N-1:0] txGo, txBusy, rxStb, lineTxd, lineRxd;
  logic [N-1:0][7:0] rxByte;
  logic [N-1:0][io_selector_pkg::CNT_W-1:0] bitCycles;
  logic match0, match1, hit, mute;
  io_selector_pkg::order_t ord;
  logic [io_selector_pkg::CHAN_W:0] txLoc, rxLoc;
  logic [7:0] rdata;
  logic wantReply;

  function automatic logic [io_selector_pkg::CNT_W-1:0] rateCycles(
    input logic [2:0] code
  );
    int idx;
    idx = (int'(code) < io_selector_pkg::NRATES) ? int'(code) : 0;
    return io_selector_pkg::CNT_W'(CLK_HZ / io_selector_pkg::RATE_BPS[idx]);
  endfunction

  // full code compared each cycle; partner code taken only for backups
  function automatic logic codeHit(input io_selector_pkg::order_t o,
                                   input logic pf,
                                   input logic [N-1:0] bk);
    return o.valid && (o.unit == UNIT_CODE ||
                       (pf && o.unit == PARTNER_CODE && bk[o.chan]));
  endfunction

  assign match0 = codeHit(wrBus0, partnerFail, backup_r);
  assign match1 = codeHit(wrBus1, partnerFail, backup_r);
  assign hit = match0 || match1;
  assign ord = match0 ? wrBus0 : wrBus1;
  assign mute = maintPulse[io_selector_pkg::MP_MUTE];
  assign txLoc = io_selector_pkg::MEM_TX_BASE + {1'b0, ord.chan};
  assign rxLoc = io_selector_pkg::MEM_RX_BASE + {1'b0, ord.chan};
  assign rdata = (ord.op == io_selector_pkg::OP_POLL) ? srq_r : mem_r[rxLoc];
  assign wantReply = hit && !mute && (ord.op == io_selector_pkg::OP_READ ||
                                      ord.op == io_selector_pkg::OP_POLL);

  always_comb begin
    mem_nxt = mem_r;
    txPend_nxt = txPend_r & ~txGo;
    srq_nxt = srq_r;
    rate_nxt = rate_r;
    backup_nxt = backup_r;
    reply0_nxt = '0;
    reply1_nxt = '0;
    if (maintPulse[io_selector_pkg::MP_CLEAR]) begin
      txPend_nxt = '0;
      srq_nxt = '0;
    end
    if (hit) begin
      unique case (ord.op)
        io_selector_pkg::OP_WRITE: begin
          mem_nxt[txLoc] = ord.data;
          txPend_nxt[ord.chan] = 1'b1;
        end
        io_selector_pkg::OP_READ: begin
          srq_nxt[ord.chan] = 1'b0;
        end
        io_selector_pkg::OP_POLL: begin
        end
        io_selector_pkg::OP_CONFIG: begin
          if (int'(ord.data[2:0]) < io_selector_pkg::NRATES) begin
            rate_nxt[ord.chan] = ord.data[2:0];
          end
          backup_nxt[ord.chan] = ord.data[io_selector_pkg::CFG_BACKUP_BIT];
        end
      endcase
    end
    // received bytes land in fixed slots; a new request beats a clear
    for (int c = 0; c < N; c++) begin
      if (rxStb[c]) begin
        mem_nxt[io_selector_pkg::MEM_RX_BASE + c] = rxByte[c];
        srq_nxt[c] = 1'b1;
      end
    end
    if (wantReply) begin
      reply0_nxt = '{valid: ord.replySel[0], data: rdata};
      reply1_nxt = '{valid: ord.replySel[1], data: rdata};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < io_selector_pkg::MEM_DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      txPend_r <= '0;
      srq_r <= '0;
      backup_r <= '0;
      rate_r <= {N{io_selector_pkg::RATE_RESET}};
      reply0_r <= '0;
      reply1_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      txPend_r <= txPend_nxt;
      srq_r <= srq_nxt;
      backup_r <= backup_nxt;
      rate_r <= rate_nxt;
      reply0_r <= reply0_nxt;
      reply1_r <= reply1_nxt;
    end
  end

  assign replyBus0 = reply0_r;
  assign replyBus1 = reply1_r;

  // one line unit per channel, eight per selector
  for (genvar c = 0; c < N; c++) begin : g_line
    assign txGo[c] = txPend_r[c] && !txBusy[c];
    assign bitCycles[c] = rateCycles(rate_r[c]);
    assign lineRxd[c] = maintPulse[io_selector_pkg::MP_LOOP] ?
                        lineTxd[c] : rxd[c];
    assign termTxd[c] = {io_selector_pkg::TERMS{lineTxd[c]}};
    io_line_unit u_line (
      .mclk(mclk),
      .nrst(nrst),
      .bitCycles(bitCycles[c]),
      .txGo(txGo[c]),
      .txByte(mem_r[io_selector_pkg::MEM_TX_BASE + c]),
      .rxd(lineRxd[c]),
      .txBusy(txBusy[c]),
      .txd(lineTxd[c]),
      .rxStb(rxStb[c]),
      .rxByte(rxByte[c])
    );
    chk_terminal_fanout: assert property (@(posedge mclk)
      disable iff (!nrst)
      termTxd[c] == {3{txBusy[c] ? termTxd[c][0] : 1'b1}})
      else $error("terminal copies differ or line not idle high");
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_order(logic [1:0] op);
    hit && ord.op == op;
  endsequence

  chk_foreign_code_quiet: assert property (
    !hit |=> !replyBus0.valid && !replyBus1.valid)
    else $error("reply driven without a code match");
  chk_reply_both_buses: assert property (
    s_order(io_selector_pkg::OP_READ) ##0 (ord.replySel == 2'h3 && !mute)
    |=> replyBus0.valid && replyBus1.valid &&
        replyBus0.data == replyBus1.data)
    else $error("both reply buses not driven alike");
  chk_read_from_slot: assert property (
    s_order(io_selector_pkg::OP_READ) ##0 (ord.replySel[0] && !mute)
    |=> replyBus0.data == $past(mem_r[rxLoc]))
    else $error("read reply not from fixed slot");
  chk_poll_vector: assert property (
    s_order(io_selector_pkg::OP_POLL) ##0 (ord.replySel[1] && !mute)
    |=> replyBus1.valid && replyBus1.data == $past(srq_r))
    else $error("poll reply wrong");
  chk_write_queues_tx: assert property (
    s_order(io_selector_pkg::OP_WRITE) ##0 !txBusy[ord.chan]
    |=> txPend_r[$past(ord.chan)] ##1 txBusy[$past(ord.chan, 2)])
    else $error("write order did not start transmission");
  chk_rx_sets_request: assert property (
    rxStb != '0 |=> (srq_r & $past(rxStb)) == $past(rxStb))
    else $error("received byte lost its request");
  chk_rate_config: assert property (
    s_order(io_selector_pkg::OP_CONFIG) ##0 (ord.data[2:0] != 3'h7)
    |=> rate_r[$past(ord.chan)] == $past(ord.data[2:0]))
    else $error("rate not taken");
  chk_maint_mute: assert property (
    mute |=> !replyBus0.valid && !replyBus1.valid)
    else $error("reply while muted");
  chk_maint_clear: assert property (
    maintPulse[io_selector_pkg::MP_CLEAR] && rxStb == '0 |=> srq_r == '0)
    else $error("clear pulse left a service request");
endmodule

// file: terminal_model.sv
// serial terminal model on the selector's line side
`timescale 1ns/1ns
module terminal_model (
  input wire logic mclk,
  input wire logic [7:0][2:0] termTxd,
  output logic [7:0] rxd
);
  int bitCycles = 10;
  initial rxd = '1;
  // 8N1, lsb first, idle high; stop level chosen by caller
  task automatic send(input int c, input logic [7:0] b, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd[c] = f[i];
      repeat (bitCycles) @(negedge mclk);
    end
    rxd[c] = 1'b1;
  endtask
  // mid-bit sampling, all three copies must agree
  task automatic recv(input int c, output logic [7:0] b, output logic ok);
    logic [9:0] f;
    int n;
    ok = 1'b1;
    for (n = 0; n < 2000 && termTxd[c][0] !== 1'b0; n++) @(negedge mclk);
    repeat (bitCycles / 2) @(negedge mclk);
    for (int i = 0; i < 10; i++) begin
      f[i] = termTxd[c][0];
      if (termTxd[c] !== {3{f[i]}}) ok = 1'b0;
      repeat (bitCycles) @(negedge mclk);
    end
    b = f[8:1];
    ok = ok && f[0] === 1'b0 && f[9] === 1'b1 && n < 2000;
  endtask
endmodule

// file: coded_io_channel_selector_tb.sv
// self-checking bench for the coded channel selector
`timescale 1ns/1ns
module coded_io_channel_selector_tb;
  localparam logic [4:0] ME = 5'h01;
  localparam logic [4:0] PT = 5'h02;
  localparam int CLKH = 96000;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  io_selector_pkg::order_t wrBus0 = '0;
  io_selector_pkg::order_t wrBus1 = '0;
  logic [2:0] maintPulse = 3'h0;
  logic partnerFail = 1'b0;
  logic [7:0] rxd;
  logic [7:0][2:0] termTxd;
  io_selector_pkg::reply_t replyBus0;
  io_selector_pkg::reply_t replyBus1;
  int fails = 0;
  int checked = 0;
  int seed = 32'h3aa4df94;
  logic [7:0] exp0[$];
  logic [7:0] exp1[$];
  logic [7:0] d;
  logic [7:0] got;
  logic ok;
  logic [8:0] w0, w1;
  logic [1:0] s;
  always #4 mclk = ~mclk;
  coded_io_channel_selector #(.UNIT_CODE(ME), .PARTNER_CODE(PT),
    .CLK_HZ(CLKH)) uut (.mclk(mclk), .nrst(nrst), .wrBus0(wrBus0),
    .wrBus1(wrBus1), .maintPulse(maintPulse), .partnerFail(partnerFail),
    .rxd(rxd), .termTxd(termTxd), .replyBus0(replyBus0),
    .replyBus1(replyBus1));
  terminal_model term (.mclk(mclk), .termTxd(termTxd), .rxd(rxd));
  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    checked++;
    if (seen !== want) begin
      fails++;
      $display("ERROR %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic put(input logic [1:0] sel, input logic [7:0] v);
    if (sel[0]) exp0.push_back(v);
    if (sel[1]) exp1.push_back(v);
  endtask
  // bus 2 puts the same order on both buses, bus 1 copy replying on 1
  task automatic order(input int bus, input logic [4:0] u,
      input logic [2:0] c, input logic [1:0] op, input logic [1:0] sel,
      input logic [7:0] v);
    io_selector_pkg::order_t o;
    o = '{1'b1, u, c, op, sel, v};
    @(negedge mclk);
    if (bus != 1) wrBus0 = o;
    o.replySel = (bus == 2) ? 2'b10 : sel;
    if (bus != 0) wrBus1 = o;
    @(negedge mclk);
    wrBus0.valid = 1'b0;
    wrBus1.valid = 1'b0;
  endtask
  task automatic txCheck(input int c);
    d = $random(seed);
    fork
      order(c % 2, ME, c, io_selector_pkg::OP_WRITE, 2'b11, d);
      term.recv(c, got, ok);
    join
    check({ok, got}, {1'b1, d});
  endtask
  always @(negedge mclk) begin
    if (nrst && replyBus0.valid !== 1'b0) begin
      w0 = exp0.size() ? {1'b1, exp0.pop_front()} : 9'h000;
      check(replyBus0, w0);
    end
    if (nrst && replyBus1.valid !== 1'b0) begin
      w1 = exp1.size() ? {1'b1, exp1.pop_front()} : 9'h000;
      check(replyBus1, w1);
    end
  end
  initial begin
    #400_000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    check({termTxd, replyBus0, replyBus1}, {24'hff_ffff, 18'h0});
    put(2'b11, 8'h00);
    order(0, ME, 0, io_selector_pkg::OP_POLL, 2'b11, 8'h00);
    order(0, 5'h1f, 0, io_selector_pkg::OP_POLL, 2'b11, 8'h00);
    order(1, 5'h00, 0, io_selector_pkg::OP_POLL, 2'b11, 8'h00);
    order(0, ME, 0, io_selector_pkg::OP_POLL, 2'b00, 8'h00);
    for (int c = 0; c < 8; c++) begin
      d = $random(seed);
      term.send(c, d, 1'b1);
      repeat (4) @(negedge mclk);
      put(2'b10, 8'h01 << c);
      order(1, ME, c, io_selector_pkg::OP_POLL, 2'b10, 8'h00);
      s = 2'(c % 3) + 2'b01;
      put(s, d);
      order(c % 2, ME, c, io_selector_pkg::OP_READ, s,
        8'h00);
      put(2'b01, 8'h00);
      order(0, ME, c, io_selector_pkg::OP_POLL, 2'b01, 8'h00);
    end
    term.send(2, 8'h5a, 1'b0);
    repeat (4) @(negedge mclk);
    put(2'b01, 8'h00);
    order(0, ME, 2, io_selector_pkg::OP_POLL, 2'b01, 8'h00);
    txCheck(0);
    txCheck(7);
    for (int k = 0; k < 7; k++) begin
      order(0, ME, 3, io_selector_pkg::OP_CONFIG, 2'b00, k[7:0]);
      order(1, ME, 3, io_selector_pkg::OP_CONFIG, 2'b00, 8'h07);
      term.bitCycles = CLKH / io_selector_pkg::RATE_BPS[k];
      txCheck(3);
    end
    term.bitCycles = 10;
    order(0, ME, 3, io_selector_pkg::OP_CONFIG, 2'b00, 8'h06);
    maintPulse = 3'b100;
    term.send(4, 8'hc3, 1'b1);
    repeat (4) @(negedge mclk);
    order(0, ME, 4, io_selector_pkg::OP_POLL, 2'b11, 8'h00);
    maintPulse = 3'b000;
    put(2'b01, 8'h10);
    order(0, ME, 4, io_selector_pkg::OP_POLL, 2'b01, 8'h00);
    maintPulse = 3'b001;
    repeat (2) @(negedge mclk);
    maintPulse = 3'b010;
    put(2'b01, 8'h00);
    order(0, ME, 4, io_selector_pkg::OP_POLL, 2'b01, 8'h00);
    order(0, ME, 1, io_selector_pkg::OP_WRITE, 2'b00, 8'h96);
    repeat (120) @(negedge mclk);
    maintPulse = 3'b000;
    put(2'b01, 8'h96);
    order(0, ME, 1, io_selector_pkg::OP_READ, 2'b01, 8'h00);
    put(2'b01, 8'h00);
    order(2, ME, 0, io_selector_pkg::OP_POLL, 2'b01, 8'h00);
    order(0, ME, 5, io_selector_pkg::OP_CONFIG, 2'b00, 8'h0f);
    term.send(5, 8'h3c, 1'b1);
    repeat (4) @(negedge mclk);
    order(0, PT, 5, io_selector_pkg::OP_READ, 2'b01, 8'h00);
    partnerFail = 1'b1;
    order(0, PT, 6, io_selector_pkg::OP_READ, 2'b01, 8'h00);
    put(2'b10, 8'h3c);
    order(1, PT, 5, io_selector_pkg::OP_READ, 2'b10, 8'h00);
    partnerFail = 1'b0;
    repeat (4) @(negedge mclk);
    check(exp0.size() + exp1.size(), 24'h00_0000);
    stop_test();
  end
endmodule
